//--- rtl/otpsec_top.sv
// otp store, security register, boot loader and jtag id reporting for one tile
// Contract
// - otp store is four sectors of 512 rows, 32 bits each, 8 KB
// - security register loads from otp at power up before features act
// - remaining otp contents copy into sram and run before other code
// - programming uses address, data and control ports at fixed resource ids
// - security bit 0 disables the jtag interface entirely
// - security bit 1 refuses link access to processor state
// - security bit 5 boots from otp address zero, skipping boot rom
// - security bit 7 enables the redundant otp rows
// - security bits 8 to 11 each block programming of one sector
// - security bit 12 blocks all otp and security programming
// - security bit 13 blocks jtag reads and writes of otp
// - security bits 15 to 21 are software accessible general purpose
// - usercode user id comes from security bits 31 to 22
// - one 128 KB 32-bit sram, any width access in one cycle
// - after reset the chain holds boundary scan and chip taps
// - jtag_device_identification returns version, part, maker with bit zero one
// - usercode returns user id, unused bits, silicon revision
`timescale 1ns/1ps
module otpsec_top
  import otpsec_pkg::*;
#(
  parameter logic [31:0] JTAG_DEVICE_IDENTIFICATION_VAL = 32'h0a5c_3e15, // arbitrary value
  parameter logic [otpsec_pkg::REV_W-1:0] SILICON_REV = 18'h02800, // arbitrary value
  parameter int SRAM_WORDS = 32768,
  parameter int SRAM_AW = 15
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire otpsec_pkg::otpsec_prog_t progPort,
  input wire logic swGpWr,
  input wire logic [otpsec_pkg::GP_W-1:0] swGpData,
  input wire logic cpuOtpRd,
  input wire logic [15:0] cpuOtpAddr,
  output logic [31:0] cpuOtpRdata,
  input wire logic cpuSramEn,
  input wire logic cpuSramWe,
  input wire logic [3:0] cpuSramBe,
  input wire logic [SRAM_AW-1:0] cpuSramAddr,
  input wire logic [31:0] cpuSramWdata,
  output logic [31:0] cpuSramRdata,
  input wire logic jtagTrstN,
  input wire logic jtagReq,
  input wire otpsec_pkg::otpsec_jbus_t jtagBus,
  output logic jtagAck,
  output logic jtagErr,
  output logic [31:0] jtagRdata,
  output logic [1:0] tapsPresent,
  output logic jtagEnabled,
  output logic linkAccessEn,
  output logic bootDone,
  output logic bootFromOtp,
  output logic [31:0] securityConfig,
  output logic progDone,
  output logic progErr
);
  import otpsec_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    otpsec_state_t st;
    logic [OTP_AW-1:0] copyIdx;
    logic secLoaded;
    logic [31:0] sec;
    logic [15:0] pAddr;
    logic [31:0] pData;
    logic progDone;
    logic progErr;
    logic jReq1;
    logic jReq2;
    logic jPrev;
    logic trst1;
    logic trst2;
    otpsec_jbus_t jBus1;
    otpsec_jbus_t jBus2;
    logic jAck;
    logic jErr;
    logic [31:0] jRdata;
    logic [31:0] cpuRdata;
    logic [1:0] taps;
    logic jtagEn;
    logic linkEn;
    logic bootDone;
    logic bootOtp;
  } otpsec_regs_t;

  otpsec_regs_t s_ff;
  otpsec_regs_t nxt_s;
  logic rstSync1_ff;
  logic rstSync2_ff;

  // nonvolatile arrays: never reset, blank reads as zero
  logic [OTP_ROW_W-1:0] otpMem [OTP_ROWS] = '{default: '0};
  logic [OTP_ROW_W-1:0] redMem [OTP_REDUN_ROWS] = '{default: '0};
  logic [31:0] secStore = 32'h0;

  logic otpWe;
  logic redWe;
  logic secWe;
  logic [15:0] wrAddr;
  logic [31:0] wrData;
  logic sramEn;
  logic sramWe;
  logic [3:0] sramBe;
  logic [SRAM_AW-1:0] sramAddr;
  logic [31:0] sramWdata;
  logic [31:0] cpuRow;
  logic [31:0] jRow;

  if (SRAM_WORDS * 4 != 131072 || OTP_ROWS != (1 << OTP_AW)) begin : g_chk
    $error("sram or otp geometry does not match the store layout");
  end

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  // ------------------------------------------------------------------
  // otp reads; redundant rows read as zero unless enabled
  // ------------------------------------------------------------------
  assign cpuRow = cpuOtpAddr[OTP_REDUN_BIT] ?
    (s_ff.sec[SEC_REDUN_EN] ? redMem[cpuOtpAddr[OTP_REDUN_AW-1:0]] : 32'h0) :
    otpMem[cpuOtpAddr[OTP_AW-1:0]];
  assign jRow = s_ff.jBus2.addr[OTP_REDUN_BIT] ?
    (s_ff.sec[SEC_REDUN_EN] ? redMem[s_ff.jBus2.addr[OTP_REDUN_AW-1:0]] : 32'h0) :
    otpMem[s_ff.jBus2.addr[OTP_AW-1:0]];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic ctlHit;
    logic [1:0] ctlOp;
    logic jRise;
    logic prgGo;
    logic [1:0] prgOp;
    logic [15:0] prgAddr;
    logic [31:0] prgData;
    logic blocked;
    ctlHit = 1'b0;
    ctlOp = 2'h0;
    jRise = 1'b0;
    prgGo = 1'b0;
    prgOp = 2'h0;
    prgAddr = 16'h0;
    prgData = 32'h0;
    blocked = 1'b0;
    nxt_s = s_ff;
    otpWe = 1'b0;
    redWe = 1'b0;
    secWe = 1'b0;
    wrAddr = 16'h0;
    wrData = 32'h0;
    sramEn = cpuSramEn;
    sramWe = cpuSramWe;
    sramBe = cpuSramBe;
    sramAddr = cpuSramAddr;
    sramWdata = cpuSramWdata;
    nxt_s.progDone = 1'b0;
    nxt_s.progErr = 1'b0;
    nxt_s.jAck = 1'b0;
    nxt_s.jErr = 1'b0;
    // pins cross in through two flops
    nxt_s.jReq1 = jtagReq;
    nxt_s.jReq2 = s_ff.jReq1;
    nxt_s.jPrev = s_ff.jReq2;
    nxt_s.trst1 = jtagTrstN;
    nxt_s.trst2 = s_ff.trst1;
    nxt_s.jBus1 = jtagBus;
    nxt_s.jBus2 = s_ff.jBus1;

    unique case (s_ff.st)
      ST_LOAD: begin
        nxt_s.sec = secStore;
        nxt_s.secLoaded = 1'b1;
        nxt_s.st = ST_COPY;
      end
      ST_COPY: begin
        // loader owns the sram until the copied image starts
        sramEn = 1'b1;
        sramWe = 1'b1;
        sramBe = 4'hf;
        sramAddr = SRAM_AW'(s_ff.copyIdx);
        sramWdata = otpMem[s_ff.copyIdx];
        nxt_s.copyIdx = OTP_AW'(s_ff.copyIdx + 1'b1);
        if (s_ff.copyIdx == OTP_LAST_ROW) begin
          nxt_s.st = ST_RUN;
          nxt_s.bootDone = 1'b1;
          nxt_s.bootOtp = s_ff.sec[SEC_BOOT_OTP];
        end
      end
      ST_RUN: begin
        if (swGpWr) begin
          nxt_s.sec[SEC_GP_HI:SEC_GP_LO] = swGpData;
        end
      end
      default: begin
        nxt_s.st = ST_LOAD;
      end
    endcase

    // programming ports, selected by resource id
    if (progPort.wr) begin
      unique case (progPort.rid)
        RID_OTP_ADDR: nxt_s.pAddr = progPort.wdata[15:0];
        RID_OTP_DATA: nxt_s.pData = progPort.wdata;
        RID_OTP_CTRL: begin
          ctlHit = 1'b1;
          ctlOp = progPort.wdata[1:0];
        end
        default: ;
      endcase
    end
    if (ctlHit) begin
      prgGo = 1'b1;
      prgOp = ctlOp;
      prgAddr = s_ff.pAddr;
      prgData = s_ff.pData;
    end

    // jtag requests on the synchronised rising edge of the request
    jRise = s_ff.jReq2 && !s_ff.jPrev && s_ff.trst2;
    if (jRise) begin
      nxt_s.jAck = 1'b1;
      nxt_s.jRdata = 32'h0;
      if (!s_ff.jtagEn) begin
        nxt_s.jErr = 1'b1;
      end else begin
        unique case (s_ff.jBus2.sel)
          JSEL_JTAG_DEVICE_IDENTIFICATION: nxt_s.jRdata = {JTAG_DEVICE_IDENTIFICATION_VAL[31:1], 1'b1};
          JSEL_USERCODE: begin
            nxt_s.jRdata = {s_ff.sec[SEC_UID_HI:SEC_UID_LO], {UNUSED_W{1'b0}},
              SILICON_REV};
          end
          JSEL_OTP_RD: begin
            if (s_ff.sec[SEC_JTAG_OTP_DIS]) begin
              nxt_s.jErr = 1'b1;
            end else begin
              nxt_s.jRdata = jRow;
            end
          end
          JSEL_OTP_WR: begin
            // a same-cycle processor program wins the shared write path
            if (s_ff.sec[SEC_JTAG_OTP_DIS] || ctlHit) begin
              nxt_s.jErr = 1'b1;
            end else begin
              prgGo = 1'b1;
              prgOp = CTL_OP_ROW;
              prgAddr = s_ff.jBus2.addr;
              prgData = s_ff.jBus2.data;
            end
          end
        endcase
      end
    end

    // otp writes only set bits, so each one is an or
    if (prgGo) begin
      blocked = !s_ff.secLoaded || s_ff.sec[SEC_MASTER_LOCK];
      if (prgOp == CTL_OP_ROW && !prgAddr[OTP_REDUN_BIT]) begin
        blocked = blocked ||
          s_ff.sec[SEC_LOCK_LO + int'(prgAddr[OTP_AW-1:OTP_SECT_LO])];
      end
      if (prgOp != CTL_OP_ROW && prgOp != CTL_OP_SEC) begin
        blocked = 1'b1;
      end
      if (blocked) begin
        nxt_s.progErr = 1'b1;
      end else begin
        nxt_s.progDone = 1'b1;
        wrAddr = prgAddr;
        wrData = prgData;
        secWe = (prgOp == CTL_OP_SEC);
        redWe = (prgOp == CTL_OP_ROW) && prgAddr[OTP_REDUN_BIT];
        otpWe = (prgOp == CTL_OP_ROW) && !prgAddr[OTP_REDUN_BIT];
      end
    end

    if (cpuOtpRd) begin
      nxt_s.cpuRdata = cpuRow;
    end
    nxt_s.taps = s_ff.trst2 ? TAPS_BOTH : 2'h0;
    nxt_s.jtagEn = s_ff.secLoaded && !s_ff.sec[SEC_JTAG_DIS] && s_ff.trst2;
    nxt_s.linkEn = s_ff.secLoaded && !s_ff.sec[SEC_LINK_DIS];
  end

  always_ff @(posedge mclk or negedge rstSync2_ff) begin
    if (!rstSync2_ff) begin
      s_ff <= '0;
    end else if (clkEn) begin
      s_ff <= nxt_s;
    end
  end

  // ------------------------------------------------------------------
  // nonvolatile store
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (clkEn && otpWe) begin
      otpMem[wrAddr[OTP_AW-1:0]] <= otpMem[wrAddr[OTP_AW-1:0]] | wrData;
    end
    if (clkEn && redWe) begin
      redMem[wrAddr[OTP_REDUN_AW-1:0]] <= redMem[wrAddr[OTP_REDUN_AW-1:0]] | wrData;
    end
    if (clkEn && secWe) begin
      secStore <= secStore | wrData;
    end
  end

  otpsec_sram #(.WORDS(SRAM_WORDS), .AW(SRAM_AW)) u_sram (
    .mclk(mclk),
    .clkEn(clkEn),
    .en(sramEn),
    .we(sramWe),
    .be(sramBe),
    .addr(sramAddr),
    .wdata(sramWdata),
    .rdata(cpuSramRdata)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign cpuOtpRdata = s_ff.cpuRdata;
  assign jtagAck = s_ff.jAck;
  assign jtagErr = s_ff.jErr;
  assign jtagRdata = s_ff.jRdata;
  assign tapsPresent = s_ff.taps;
  assign jtagEnabled = s_ff.jtagEn;
  assign linkAccessEn = s_ff.linkEn;
  assign bootDone = s_ff.bootDone;
  assign bootFromOtp = s_ff.bootOtp;
  assign securityConfig = s_ff.sec;
  assign progDone = s_ff.progDone;
  assign progErr = s_ff.progErr;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_load;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (clkEn && s_ff.st == ST_LOAD) |=> s_ff.secLoaded && s_ff.sec == $past(secStore);
  endproperty
  a_load: assert property (p_load) else $error("security load missed");

  property p_jtag_off;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (jtagAck && $past(s_ff.sec[SEC_JTAG_DIS])) |-> jtagErr && jtagRdata == 32'h0;
  endproperty
  a_jtag_off: assert property (p_jtag_off) else $error("jtag answered while off");

  property p_link;
    @(posedge mclk) disable iff (!rstSync2_ff)
    linkAccessEn |-> !$past(s_ff.sec[SEC_LINK_DIS]) && $past(s_ff.secLoaded);
  endproperty
  a_link: assert property (p_link) else $error("link open while disabled");

  property p_boot;
    @(posedge mclk) disable iff (!rstSync2_ff)
    $rose(bootDone) |-> bootFromOtp == securityConfig[SEC_BOOT_OTP];
  endproperty
  a_boot: assert property (p_boot) else $error("boot source wrong");

  property p_redun;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (clkEn && cpuOtpRd && cpuOtpAddr[OTP_REDUN_BIT] && !s_ff.sec[SEC_REDUN_EN])
      |=> cpuOtpRdata == 32'h0;
  endproperty
  a_redun: assert property (p_redun) else $error("redundant row seen while off");

  property p_sector;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (clkEn && progPort.wr && progPort.rid == RID_OTP_CTRL && progPort.wdata[1:0] == CTL_OP_ROW
      && !s_ff.pAddr[OTP_REDUN_BIT]
      && s_ff.sec[SEC_LOCK_LO + int'(s_ff.pAddr[OTP_AW-1:OTP_SECT_LO])])
      |=> progErr && !progDone;
  endproperty
  a_sector: assert property (p_sector) else $error("locked sector programmed");

  property p_master;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (clkEn && progPort.wr && progPort.rid == RID_OTP_CTRL && s_ff.sec[SEC_MASTER_LOCK])
      |=> progErr && !progDone;
  endproperty
  a_master: assert property (p_master) else $error("master lock bypassed");

  property p_jtag_otp;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (jtagAck && $past(s_ff.sec[SEC_JTAG_OTP_DIS])
      && $past(s_ff.jBus2.sel) inside {JSEL_OTP_RD, JSEL_OTP_WR}) |-> jtagErr;
  endproperty
  a_jtag_otp: assert property (p_jtag_otp) else $error("jtag reached otp");

  property p_jtag_device_identification;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (jtagAck && !jtagErr && $past(s_ff.jBus2.sel) == JSEL_JTAG_DEVICE_IDENTIFICATION) |-> jtagRdata[0];
  endproperty
  a_jtag_device_identification: assert property (p_jtag_device_identification) else $error("jtag_device_identification bit zero clear");

  property p_user;
    @(posedge mclk) disable iff (!rstSync2_ff)
    (jtagAck && !jtagErr && $past(s_ff.jBus2.sel) == JSEL_USERCODE)
      |-> jtagRdata[31:22] == $past(s_ff.sec[SEC_UID_HI:SEC_UID_LO])
        && jtagRdata[REV_W-1:0] == SILICON_REV;
  endproperty
  a_user: assert property (p_user) else $error("usercode layout wrong");

  property p_preload;
    @(posedge mclk) disable iff (!rstSync2_ff)
    !s_ff.secLoaded |=> !jtagEnabled && !linkAccessEn;
  endproperty
  a_preload: assert property (p_preload) else $error("access open before load");
endmodule

//--- rtl/otpsec_pkg.sv
// shared constants and carriers for the otp security and jtag identification block
package otpsec_pkg;
  // ------------------------------------------------------------------
  // otp geometry
  // ------------------------------------------------------------------
  localparam int OTP_SECTORS = 4;
  localparam int OTP_SEC_ROWS = 512;
  localparam int OTP_ROW_W = 32;
  localparam int OTP_ROWS = OTP_SECTORS * OTP_SEC_ROWS;
  localparam int OTP_AW = 11;
  localparam int OTP_SECT_LO = 9;
  localparam int OTP_REDUN_BIT = 11;
  localparam int OTP_REDUN_ROWS = 8;
  localparam int OTP_REDUN_AW = 3;
  localparam logic [OTP_AW-1:0] OTP_LAST_ROW = 11'h7ff;
  // ------------------------------------------------------------------
  // programming port resource identifiers
  // ------------------------------------------------------------------
  localparam logic [23:0] RID_OTP_ADDR = 24'h100200;
  localparam logic [23:0] RID_OTP_DATA = 24'h200100;
  localparam logic [23:0] RID_OTP_CTRL = 24'h100300;
  localparam logic [1:0] CTL_OP_ROW = 2'h1;
  localparam logic [1:0] CTL_OP_SEC = 2'h2;
  // ------------------------------------------------------------------
  // security_config bit positions
  // ------------------------------------------------------------------
  localparam int SEC_JTAG_DIS = 0;
  localparam int SEC_LINK_DIS = 1;
  localparam int SEC_BOOT_OTP = 5;
  localparam int SEC_REDUN_EN = 7;
  localparam int SEC_LOCK_LO = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_DIS = 13;
  localparam int SEC_GP_LO = 15;
  localparam int SEC_GP_HI = 21;
  localparam int SEC_UID_LO = 22;
  localparam int SEC_UID_HI = 31;
  localparam int GP_W = SEC_GP_HI - SEC_GP_LO + 1;
  localparam int UID_W = SEC_UID_HI - SEC_UID_LO + 1;
  // ------------------------------------------------------------------
  // jtag usercode layout and requests
  // ------------------------------------------------------------------
  localparam int REV_W = 18;
  localparam int UNUSED_W = 32 - UID_W - REV_W;
  localparam logic [1:0] TAPS_BOTH = 2'h3;
  typedef enum logic [1:0] {
    JSEL_JTAG_DEVICE_IDENTIFICATION = 2'b00,
    JSEL_USERCODE = 2'b01,
    JSEL_OTP_RD = 2'b10,
    JSEL_OTP_WR = 2'b11
  } otpsec_jsel_t;
  typedef struct packed {
    otpsec_jsel_t sel;
    logic [15:0] addr;
    logic [31:0] data;
  } otpsec_jbus_t;
  typedef struct packed {
    logic wr;
    logic [23:0] rid;
    logic [31:0] wdata;
  } otpsec_prog_t;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_COPY = 2'b01,
    ST_RUN = 2'b10
  } otpsec_state_t;
endpackage

//--- rtl/otpsec_sram.sv
// single-bank word-wide tile sram with byte lanes
`timescale 1ns/1ps
module otpsec_sram #(
  parameter int WORDS = 32768,
  parameter int AW = 15
) (
  input wire logic mclk,
  input wire logic clkEn,
  input wire logic en,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [WORDS];

  if (WORDS != (1 << AW)) begin : g_chk
    $error("sram depth must equal two to the address width");
  end

  // one access per cycle, byte, half or word by lane enables
  always_ff @(posedge mclk) begin
    if (clkEn && en) begin
      if (we) begin
        for (int b = 0; b < 4; b++) begin
          if (be[b]) begin
            mem[addr][8*b +: 8] <= wdata[8*b +: 8];
          end
        end
      end else begin
        rdata <= mem[addr];
      end
    end
  end
endmodule

//--- dv/otpsec_jtag_host.sv
// jtag host model driving test reset, request and bus pins
`timescale 1ns/1ps
module otpsec_jtag_host
  import otpsec_pkg::*;
(
  input wire logic mclk,
  output logic jtagTrstN,
  output logic jtagReq,
  output otpsec_pkg::otpsec_jbus_t jtagBus,
  input wire logic jtagAck,
  input wire logic jtagErr,
  input wire logic [31:0] jtagRdata
);
  initial begin
    jtagTrstN = 1'b0;
    jtagReq = 1'b0;
    jtagBus = '0;
  end
  // held low well past power up, more than 100 ns
  task automatic releaseTrst();
    repeat (30) @(posedge mclk);
    #1 jtagTrstN = 1'b1;
  endtask
  task automatic xfer(input otpsec_jsel_t sel, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    @(posedge mclk);
    #1;
    jtagBus = '{sel: sel, addr: a, data: d};
    jtagReq = 1'b1;
    ok = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge mclk);
      #1;
      ok = (jtagAck === 1'b1);
    end
    rd = jtagRdata;
    err = jtagErr;
    jtagReq = 1'b0;
    // released bus shows junk, never the last request
    jtagBus = ~jtagBus;
    repeat (4) @(posedge mclk);
  endtask
endmodule

//--- dv/tb.sv
// self-checking bench for the otp security and jtag id block
`timescale 1ns/1ps
module tb;
  import otpsec_pkg::*;
  localparam logic [31:0] IDV = 32'h5a5a_1234; // arbitrary value
  localparam logic [REV_W-1:0] SREV = 18'h1c3a5; // arbitrary value
  logic mclk, resetn, clkEn, swGpWr, cpuOtpRd, cpuSramEn, cpuSramWe;
  otpsec_prog_t progPort;
  otpsec_jbus_t jtagBus;
  logic [GP_W-1:0] swGpData;
  logic [15:0] cpuOtpAddr;
  logic [3:0] cpuSramBe, be;
  logic [14:0] cpuSramAddr;
  logic [31:0] cpuSramWdata, cpuOtpRdata, cpuSramRdata, jtagRdata, securityConfig;
  logic jtagTrstN, jtagReq, jtagAck, jtagErr, jtagEnabled, linkAccessEn;
  logic bootDone, bootFromOtp, progDone, progErr, err, ok;
  logic [1:0] tapsPresent;
  logic [31:0] otpM [int];
  logic [31:0] secM, secStore, rd, d0, d1;
  integer seed = 8;
  int miscompares = 0;
  int nCompared = 0;
  int a;
  int rows [4];

  otpsec_top #(.JTAG_DEVICE_IDENTIFICATION_VAL(IDV), .SILICON_REV(SREV)) dut (.mclk, .resetn, .clkEn, .progPort,
    .swGpWr, .swGpData, .cpuOtpRd, .cpuOtpAddr, .cpuOtpRdata, .cpuSramEn, .cpuSramWe,
    .cpuSramBe, .cpuSramAddr, .cpuSramWdata, .cpuSramRdata, .jtagTrstN, .jtagReq, .jtagBus,
    .jtagAck, .jtagErr, .jtagRdata, .tapsPresent, .jtagEnabled, .linkAccessEn, .bootDone,
    .bootFromOtp, .securityConfig, .progDone, .progErr);
  otpsec_jtag_host host (.mclk, .jtagTrstN, .jtagReq, .jtagBus, .jtagAck, .jtagErr,
    .jtagRdata);

  // ------------------------------------------------------------------
  // clock, watchdog, helpers
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // three boots of about 2100 cycles each fit well inside
  initial begin
    #200000;
    miscompares++;
    endSim();
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    if (miscompares == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [31:0] otpE(input int ad);
    return otpM.exists(ad) ? otpM[ad] : 32'h0;
  endfunction
  task automatic doReset();
    int n;
    @(posedge mclk);
    #1 resetn = 1'b0;
    repeat (10) @(posedge mclk);
    #1 cmp(linkAccessEn, 0);
    resetn = 1'b1;
    secM = secStore;
    for (n = 0; n < 3000 && bootDone !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    cmp(bootDone, 1);
  endtask
  task automatic prog(input logic [23:0] rid, input logic [31:0] d);
    progPort = '{wr: 1'b1, rid: rid, wdata: d};
    @(posedge mclk);
    #1;
  endtask
  task automatic progOp(input logic [1:0] op, input int ad, input logic [31:0] d,
      input logic bad);
    int n;
    prog(RID_OTP_ADDR, {16'h0, 16'(ad)});
    prog(RID_OTP_DATA, d);
    prog(RID_OTP_CTRL, {30'h0, op});
    progPort.wr = 1'b0;
    for (n = 0; n < 3 && (progDone | progErr) !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    cmp({progErr, progDone}, {bad, !bad});
    // idle cycle so the next strobe never lands in the same step
    @(posedge mclk);
    #1;
  endtask
  task automatic progRow(input int ad, input logic [31:0] d);
    logic bad;
    bad = secM[SEC_MASTER_LOCK] | secM[SEC_LOCK_LO + ad / 512];
    progOp(CTL_OP_ROW, ad, d, bad);
    if (!bad) otpM[ad] = otpE(ad) | d;
  endtask
  task automatic otpRd(input int ad);
    cpuOtpRd = 1'b1;
    cpuOtpAddr = 16'(ad);
    @(posedge mclk);
    #1 cpuOtpRd = 1'b0;
    cmp(cpuOtpRdata, otpE(ad));
  endtask
  task automatic sram(input logic we, input logic [3:0] b, input int ad, input logic [31:0] d);
    cpuSramEn = 1'b1;
    cpuSramWe = we;
    cpuSramBe = b;
    cpuSramAddr = 15'(ad);
    cpuSramWdata = d;
    @(posedge mclk);
    #1 cpuSramEn = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic jt(input otpsec_jsel_t s, input int ad, input logic [31:0] d,
      input logic bad, input logic [31:0] exp);
    host.xfer(s, 16'(ad), d, rd, err, ok);
    cmp({ok, err}, {1'b1, bad});
    if (!bad && s != JSEL_OTP_WR) cmp(rd, exp);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    progPort = '0;
    swGpWr = 1'b0;
    swGpData = '0;
    cpuOtpRd = 1'b0;
    cpuOtpAddr = '0;
    cpuSramEn = 1'b0;
    cpuSramWe = 1'b0;
    cpuSramBe = '0;
    cpuSramAddr = '0;
    cpuSramWdata = '0;
    secStore = 32'h0;
    doReset();
    cmp(tapsPresent, 2'h0);
    host.releaseTrst();
    repeat (4) @(posedge mclk);
    #1 cmp(tapsPresent, TAPS_BOTH);
    cmp(securityConfig, 32'h0);
    cmp({bootFromOtp, jtagEnabled, linkAccessEn}, 3'b011);
    jt(JSEL_JTAG_DEVICE_IDENTIFICATION, 0, 0, 1'b0, IDV | 32'h1);
    jt(JSEL_USERCODE, 0, 0, 1'b0, {10'h0, 4'h0, SREV});
    for (int s = 0; s < 4; s++) begin
      rows[s] = s * 512 + ($random(seed) & 511);
      progRow(rows[s], $random(seed));
      progRow(rows[s], $random(seed));
      otpRd(rows[s]);
    end
    // redundant row written, but hidden while its enable bit is clear
    a = 2048 + ($random(seed) & 7);
    progOp(CTL_OP_ROW, a, 32'hffff_ffff, 1'b0);
    otpRd(a);
    a = 1024 + ($random(seed) & 511);
    d0 = $random(seed);
    jt(JSEL_OTP_WR, a, d0, 1'b0, 0);
    otpM[a] = otpE(a) | d0;
    jt(JSEL_OTP_RD, a, 0, 1'b0, otpM[a]);
    for (int i = 0; i < 6; i++) begin
      a = $random(seed) & 32767;
      d0 = $random(seed);
      d1 = $random(seed);
      be = 4'($random(seed));
      sram(1'b1, 4'hf, a, d0);
      sram(1'b1, be, a, d1);
      sram(1'b0, 4'h0, a, 0);
      for (int b = 0; b < 4; b++) if (be[b]) d0[8*b +: 8] = d1[8*b +: 8];
      cmp(cpuSramRdata, d0);
    end
    swGpData = GP_W'($random(seed)) | GP_W'(1);
    swGpWr = 1'b1;
    // clock enable low must freeze the register
    clkEn = 1'b0;
    @(posedge mclk);
    #1 cmp(securityConfig, 32'h0);
    clkEn = 1'b1;
    @(posedge mclk);
    #1 swGpWr = 1'b0;
    @(posedge mclk);
    #1 cmp(securityConfig[SEC_GP_HI:SEC_GP_LO], swGpData);
    // user id, sector 0 lock, jtag otp access off
    d0 = {10'($random(seed)), 22'h0} | 32'h0000_2100;
    progOp(CTL_OP_SEC, 0, d0, 1'b0);
    secStore |= d0;
    cmp(securityConfig[SEC_JTAG_OTP_DIS], 0);
    doReset();
    cmp(securityConfig, secM);
    jt(JSEL_USERCODE, 0, 0, 1'b0, {secM[31:22], 4'h0, SREV});
    sram(1'b0, 4'h0, rows[1], 0);
    cmp(cpuSramRdata, otpE(rows[1]));
    progRow(rows[0], 32'hffff_ffff);
    progRow(rows[1], 32'h8000_0001);
    otpRd(rows[0]);
    jt(JSEL_OTP_RD, rows[1], 0, 1'b1, 0);
    // jtag and link off, otp boot, master lock
    d1 = 32'h0000_1023;
    progOp(CTL_OP_SEC, 0, d1, 1'b0);
    secStore |= d1;
    doReset();
    cmp(securityConfig, secM);
    cmp({bootFromOtp, jtagEnabled, linkAccessEn}, 3'b100);
    jt(JSEL_JTAG_DEVICE_IDENTIFICATION, 0, 0, 1'b1, 0);
    cmp(rd, 32'h0);
    progRow(rows[3], 32'h1);
    progOp(CTL_OP_SEC, 0, 32'h4, 1'b1);
    endSim();
  end
endmodule
